/* File: inc/wdtnr_pkg.sv */
package wdtnr_pkg;
  // ---------------------------------------------------------------
  // register map (byte addresses on the byte-addressed bus)
  // ---------------------------------------------------------------
  localparam logic [3:0] MODE_OFS = 4'h0;
  localparam logic [3:0] CMD_OFS = 4'h4;
  localparam logic [3:0] STAT_OFS = 4'h8;
  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int ENABLE_POS = 7;
  localparam int TSEL_LSB = 4;
  localparam int IDLE_RUN_POS = 2;
  localparam int ACTION_POS = 1;
  localparam logic ENABLE_RST = 1'b1;
  localparam logic [2:0] TSEL_RST = 3'h0;
  localparam logic IDLE_RUN_RST = 1'b0;
  localparam logic ACTION_RST = 1'b1;
  localparam logic [7:0] DISABLE_CODE = 8'hB1;
  localparam logic [7:0] CLEAR_CODE = 8'h4E;
  // ---------------------------------------------------------------
  // counts
  // ---------------------------------------------------------------
  localparam int CNT_W = 25;
  localparam logic [5:0] RESET_HOLD_STATES = 6'h20;
  typedef struct packed {
    logic enable;
    logic [2:0] tsel;
    logic idle_run;
    logic action;
  } wdtnr_mode_s;
endpackage

/* File: rtl/wdtnr_top.sv */
// Chosen here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/100ps
`default_nettype none
// Behaviour
// R1: counter on system clock, selectable timeout
// R2: select 0-5 gives 2^15..2^25, 6/7 prohibited
// R3: write-only command: B1 disable, 4E clear
// R4: clear code zeroes counter, counting resumes
// R5: disable code with enable low stops, clears
// R6: setting enable bit re-enables watchdog
// R7: enable bit resets to one
// R8: timeout select resets to zero
// R9: overflow action resets to internal reset
// R10: action zero: overflow raises NMI interrupt
// R11: NMI flag bit zero marks watchdog
// R12: fault output low until clear code
// R13: action one: internal reset for 32 states
// R14: watchdog reset selects internal oscillator clock
// R15: debug mode freezes counter
// R16: idle mode governed by idle-run bit
// R17: idle-run zero stops, one runs
// R18: software clears before timeout
// R19: software disables before deep stop
// R20: reserved command codes have no effect
module wdtnr_top (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic clk_en_i,
  input wire logic debug_mode_i,
  input wire logic idle_mode_i,
  input wire logic nmi_flag_clr_i,
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic watchdog_overflow_irq_o,
  output logic nmi_source_watchdog_o,
  output logic fault_output_n_o,
  output logic wdt_reset_o,
  output logic clk_sel_internal_o
);
  // ---------------------------------------------------------------
  // bus decode
  // ---------------------------------------------------------------
  logic ack_q;
  logic ack_d;
  wire logic req = (avs_read_i | avs_write_i) & ~ack_q;
  wire logic wr_acc = avs_write_i & ack_q;
  wire logic lane0 = avs_byteenable_i[0];
  wire logic wr_mode = wr_acc & lane0 & (avs_address_i == wdtnr_pkg::MODE_OFS);
  wire logic wr_cmd = wr_acc & lane0 & (avs_address_i == wdtnr_pkg::CMD_OFS);
  wire logic [7:0] cmd_byte = avs_writedata_i[7:0];
  wdtnr_pkg::wdtnr_mode_s mode_q;
  wdtnr_pkg::wdtnr_mode_s mode_d;
  logic [wdtnr_pkg::CNT_W-1:0] cnt_q;
  logic [wdtnr_pkg::CNT_W-1:0] cnt_d;
  logic irq_q;
  logic flag_q;
  logic fault_n_q;
  logic [5:0] hold_q;
  logic [5:0] hold_d;
  logic rst_out_q;
  logic clk_int_q;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  wire logic do_clear = wr_cmd & (cmd_byte == wdtnr_pkg::CLEAR_CODE); // R4 R20
  wire logic do_disable = wr_cmd & (cmd_byte == wdtnr_pkg::DISABLE_CODE)
                          & ~mode_q.enable; // R5 R20
  // running state: enable bit only disarms once disable code lands
  logic running_q;
  wire logic running_d = (wr_mode & avs_writedata_i[wdtnr_pkg::ENABLE_POS]) ? 1'b1 // R6
                         : (do_disable ? 1'b0 : running_q); // R5
  // ---------------------------------------------------------------
  // counter and overflow
  // ---------------------------------------------------------------
  wire logic idle_block = idle_mode_i & ~mode_q.idle_run; // R16 R17
  wire logic advance = running_q & ~debug_mode_i & ~idle_block & ~rst_out_q; // R15
  // top_bit is the exponent N of the selected 2^N period
  wire logic [4:0] top_bit = 5'(15 + 2 * int'(mode_q.tsel)); // R2
  wire logic legal_sel = mode_q.tsel <= 3'h5; // R2
  // overflow once the low N bits are all ones, so the period is 2^N
  wire logic ovf = advance & legal_sel
                   & (&(cnt_q | ~((25'h1 << top_bit) - 25'h1))); // R1
  wire logic ovf_irq = ovf & ~mode_q.action; // R10
  wire logic ovf_rst = ovf & mode_q.action; // R13
  always_comb begin
    cnt_d = cnt_q;
    if (do_clear || do_disable || ovf) begin
      cnt_d = '0; // R4 R5
    end else if (advance) begin
      cnt_d = cnt_q + 25'h1; // R1
    end
  end
  // ---------------------------------------------------------------
  // mode register and reset hold
  // ---------------------------------------------------------------
  always_comb begin
    mode_d = mode_q;
    if (ovf_rst) begin
      mode_d.enable = wdtnr_pkg::ENABLE_RST; // R7
      mode_d.tsel = wdtnr_pkg::TSEL_RST; // R8
      mode_d.idle_run = wdtnr_pkg::IDLE_RUN_RST;
      mode_d.action = wdtnr_pkg::ACTION_RST; // R9
    end else if (wr_mode) begin
      mode_d.enable = avs_writedata_i[wdtnr_pkg::ENABLE_POS];
      mode_d.tsel = avs_writedata_i[wdtnr_pkg::TSEL_LSB+:3];
      mode_d.idle_run = avs_writedata_i[wdtnr_pkg::IDLE_RUN_POS];
      mode_d.action = avs_writedata_i[wdtnr_pkg::ACTION_POS];
    end
  end
  always_comb begin
    hold_d = hold_q;
    if (ovf_rst) begin
      hold_d = wdtnr_pkg::RESET_HOLD_STATES; // R13
    end else if (hold_q != 6'h0) begin
      hold_d = hold_q - 6'h1;
    end
  end
  // ---------------------------------------------------------------
  // read mux
  // ---------------------------------------------------------------
  always_comb begin
    rdata_d = 32'h0;
    if (avs_address_i == wdtnr_pkg::MODE_OFS) begin
      rdata_d[wdtnr_pkg::ENABLE_POS] = mode_q.enable;
      rdata_d[wdtnr_pkg::TSEL_LSB+:3] = mode_q.tsel;
      rdata_d[wdtnr_pkg::IDLE_RUN_POS] = mode_q.idle_run;
      rdata_d[wdtnr_pkg::ACTION_POS] = mode_q.action;
    end else if (avs_address_i == wdtnr_pkg::STAT_OFS) begin
      rdata_d[0] = flag_q; // R11
      rdata_d[1] = running_q;
      rdata_d[2] = ~fault_n_q;
    end
  end
  assign ack_d = req;
  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      mode_q <= '{enable: wdtnr_pkg::ENABLE_RST, tsel: wdtnr_pkg::TSEL_RST, // R7 R8
                  idle_run: wdtnr_pkg::IDLE_RUN_RST, action: wdtnr_pkg::ACTION_RST}; // R9
      running_q <= 1'b1; // R7
      cnt_q <= '0;
      hold_q <= 6'h0;
      ack_q <= 1'b0;
      rdata_q <= 32'h0;
    end else if (clk_en_i) begin
      mode_q <= mode_d;
      running_q <= ovf_rst ? 1'b1 : running_d;
      cnt_q <= cnt_d;
      hold_q <= hold_d;
      ack_q <= ack_d;
      rdata_q <= (req & avs_read_i) ? rdata_d : 32'h0;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      irq_q <= 1'b0;
      flag_q <= 1'b0;
      fault_n_q <= 1'b1;
      rst_out_q <= 1'b0;
      clk_int_q <= 1'b0;
    end else if (clk_en_i) begin
      irq_q <= ovf_irq; // R10
      flag_q <= ovf_irq | (flag_q & ~nmi_flag_clr_i); // R11
      fault_n_q <= ovf_irq ? 1'b0 : (do_clear ? 1'b1 : fault_n_q); // R12
      rst_out_q <= ovf_rst | (hold_q > 6'h1); // R13
      clk_int_q <= ovf_rst ? 1'b1 : clk_int_q; // R14
    end
  end
  assign avs_readdata_o = rdata_q;
  assign avs_waitrequest_o = ~ack_q;
  assign watchdog_overflow_irq_o = irq_q;
  assign nmi_source_watchdog_o = flag_q;
  assign fault_output_n_o = fault_n_q;
  assign wdt_reset_o = rst_out_q;
  assign clk_sel_internal_o = clk_int_q;
endmodule
`default_nettype wire

/* File: verif/wdtnr_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module wdtnr_monitor (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic [31:0] avs_readdata_o,
  input wire logic watchdog_overflow_irq_o,
  input wire logic nmi_source_watchdog_o,
  input wire logic fault_output_n_o,
  input wire logic wdt_reset_o,
  input wire logic clk_sel_internal_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic [6:0] run_q;
  always_ff @(posedge core_clk_i) begin
    run_q <= (rst_i || !wdt_reset_o) ? 7'h00 : run_q + 7'h01;
  end
  req_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o) else $error("request not answered");
  ack_once_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o) else $error("answer longer than one cycle");
  rdata_idle_a: assert property (avs_waitrequest_o |-> avs_readdata_o == 32'h0) else $error("read data outside answer");
  irq_pulse_a: assert property (watchdog_overflow_irq_o |=> !watchdog_overflow_irq_o) else $error("irq not a pulse");
  nmi_flag_a: assert property (watchdog_overflow_irq_o |=> nmi_source_watchdog_o) else $error("nmi flag not set");
  fault_low_a: assert property (watchdog_overflow_irq_o |=> !fault_output_n_o) else $error("fault output not low");
  hold_len_a: assert property ($fell(wdt_reset_o) |-> run_q == 7'h20) else $error("reset hold not 32");
  clk_sel_a: assert property ($rose(wdt_reset_o) |-> ##[0:2] clk_sel_internal_o) else $error("clock select not set");
  cover property (watchdog_overflow_irq_o);
  cover property ($fell(wdt_reset_o));
  cover property (!avs_waitrequest_o && avs_write_i);
endmodule
`default_nettype wire

/* File: verif/testbench.sv */
`timescale 1ns/100ps
`default_nettype none
module testbench;
  localparam logic [3:0] MA = wdtnr_pkg::MODE_OFS;
  localparam logic [3:0] CA = wdtnr_pkg::CMD_OFS;
  localparam logic [3:0] SA = wdtnr_pkg::STAT_OFS;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic nclr = 1'b0;
  logic dbg = 1'b0;
  logic idl = 1'b0;
  logic cen = 1'b1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] q;
  logic [31:0] rdat;
  logic wq, irq, flag, fn, wrst, csel;
  int error_cnt = 0;
  int n_checks = 0;
  int n;
  always #12.5 clk = ~clk;
  wdtnr_top dut_u (.core_clk_i(clk), .rst_i(rst), .clk_en_i(cen), .debug_mode_i(dbg),
    .idle_mode_i(idl), .nmi_flag_clr_i(nclr), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wq), .watchdog_overflow_irq_o(irq), .nmi_source_watchdog_o(flag),
    .fault_output_n_o(fn), .wdt_reset_o(wrst), .clk_sel_internal_o(csel));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= {24'h0, d};
    do begin
      @(posedge clk);
      k++;
    end while (wq !== 1'b0 && k < 20);
    q = rdat;
    chk(k < 20, 1'b1);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic edge_wait(input int c);
    n = 0;
    while ((c == 0 ? wrst !== 1'b1 : c == 1 ? wrst === 1'b1 : irq !== 1'b1) && n < 33000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic t_wreset;
    bus(0, MA, 8'h00);
    chk(q, 32'h82);
    bus(0, CA, 8'h00);
    chk(q, 32'h0);
    bus(0, 4'hC, 8'h00);
    chk(q, 32'h0);
    edge_wait(0);
    edge_wait(1);
    chk(n, 32);
    chk(csel, 1'b1);
    $display("watchdog reset test done");
  endtask
  task automatic t_nmi;
    bus(1, MA, 8'h80);
    bus(1, CA, 8'h4E);
    repeat (16000) @(posedge clk);
    dbg <= 1'b1;
    repeat (1000) @(posedge clk);
    dbg <= 1'b0;
    idl <= 1'b1;
    repeat (1000) @(posedge clk);
    idl <= 1'b0;
    cen <= 1'b0;
    repeat (1000) @(posedge clk);
    cen <= 1'b1;
    edge_wait(2);
    chk(n > 16755 && n < 16775, 1'b1);
    @(posedge clk);
    chk(irq, 1'b0);
    chk(flag, 1'b1);
    bus(1, CA, 8'h5A);
    chk(fn, 1'b0);
    bus(1, CA, 8'h4E);
    @(posedge clk);
    chk(fn, 1'b1);
    nclr <= 1'b1;
    @(posedge clk);
    nclr <= 1'b0;
    repeat (2) @(posedge clk);
    chk(flag, 1'b0);
    $display("nmi test done");
  endtask
  task automatic t_dis;
    bus(1, CA, 8'hB1);
    bus(0, SA, 8'h00);
    chk(q[1], 1'b1);
    bus(1, MA, 8'h00);
    bus(1, CA, 8'hB1);
    bus(0, SA, 8'h00);
    chk(q[1], 1'b0);
    bus(1, MA, 8'hD0);
    bus(0, SA, 8'h00);
    chk(q[1], 1'b1);
    bus(0, MA, 8'h00);
    chk(q, 32'hD0);
    $display("disable test done");
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_wreset;
    t_nmi;
    t_dis;
    print_verdict;
  end
  initial begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    print_verdict;
  end
endmodule
bind wdtnr_top wdtnr_monitor mon_u (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_readdata_o(avs_readdata_o), .watchdog_overflow_irq_o(watchdog_overflow_irq_o),
  .nmi_source_watchdog_o(nmi_source_watchdog_o), .fault_output_n_o(fault_output_n_o),
  .wdt_reset_o(wdt_reset_o), .clk_sel_internal_o(clk_sel_internal_o));
`default_nettype wire
